// [shared/sfwp_params.svh]
// Purpose: constants of the serial flash write-protect controller
// Assumes: included by its bare name after the package
// Notes: command codes, protect bases, timing figures
`ifndef SFWP_PARAMS_SVH
`define SFWP_PARAMS_SVH

// command codes
`define SFWP_CMD_WRITE_ENABLE 8'h06
`define SFWP_CMD_WRITE_DISABLE 8'h04
`define SFWP_CMD_READ_STATUS 8'h05
`define SFWP_CMD_STATUS_WRITE 8'h01
`define SFWP_CMD_PAGE_WRITE 8'h02
`define SFWP_CMD_WIPE_4K 8'h20
`define SFWP_CMD_WIPE_64K_A 8'hD8
`define SFWP_CMD_WIPE_64K_B 8'h52
`define SFWP_CMD_WIPE_ALL_A 8'hC7
`define SFWP_CMD_WIPE_ALL_B 8'h60
`define SFWP_CMD_DEEP_SLEEP 8'hB9
`define SFWP_CMD_WAKE_ID 8'hAB
`define SFWP_CMD_ONETIME_ENTER 8'h3A

// frame byte counts
`define SFWP_HDR_BYTES 9'h004
`define SFWP_PAGE_BYTES 9'h100

// protected region bases
`define SFWP_PROT_HALF 24'h10_0000
`define SFWP_PROT_QUARTER 24'h18_0000
`define SFWP_PROT_EIGHTH 24'h1C_0000
`define SFWP_PROT_SIXTEENTH 24'h1E_0000
`define SFWP_PROT_LAST 24'h1F_0000

// interface mode value for two-bit transfer
`define SFWP_MODE_DUAL 2'h1

// reset values
`define SFWP_PROT_RST 3'h0
`define SFWP_MODE_RST 2'h0

// timing: power-up write delay in microseconds, reference clock in MHz
`define SFWP_PUW_US 1000
`define SFWP_REF_MHZ 25

`endif

// [shared/sfwp_pkg.sv]
// Purpose: types of the serial flash write-protect controller
// Assumes: nothing
// Notes: status layout is the packed field order below
package sfwp_pkg;

  // operations handed to the storage array
  typedef enum logic [2:0] {
    SFWP_ARR_PROG = 3'h0,
    SFWP_ARR_WIPE_4K = 3'h1,
    SFWP_ARR_WIPE_64K = 3'h2,
    SFWP_ARR_WIPE_ALL = 3'h3,
    SFWP_ARR_STATUS = 3'h4
  } sfwp_arr_op_type;

  // one beat towards the storage array
  typedef struct packed {
    logic valid;
    logic last;
    sfwp_arr_op_type op;
    logic otp;
    logic [23:0] addr;
    logic [7:0] data;
  } sfwp_arr_req_type;

  // status byte, bit 7 down to bit 0
  typedef struct packed {
    logic lock;
    logic [1:0] mode;
    logic [2:0] prot;
    logic latch;
    logic busy;
  } sfwp_status_type;

  // execution sequencer
  typedef enum logic [2:0] {
    SFWP_EX_IDLE = 3'h1,
    SFWP_EX_STREAM = 3'h2,
    SFWP_EX_WAIT = 3'h4
  } sfwp_exec_type;

endpackage : sfwp_pkg

// [rtl/sfwp_link.sv]
// Purpose: link-clock side of the serial flash port
// Assumes: link clock only runs while selected
// Notes: bytes and pulses leave as toggles; status enters per-bit
`timescale 1ns/1ns
`default_nettype none
`include "sfwp_params.svh"
module sfwp_link (
  input wire logic i_link_clk,
  input wire logic i_rst_n,
  input wire logic i_sel_n,
  input wire logic i_io0,
  input wire logic i_io1,
  input wire logic i_dual,
  input wire logic i_sleep,
  input wire logic [7:0] i_status,
  output logic o_pulse_tgl,
  output logic o_byte_tgl,
  output logic [7:0] o_byte,
  output logic o_io0,
  output logic o_io0_oe,
  output logic o_io1,
  output logic o_io1_oe
);
  logic frame_rst_n;
  logic [9:0] sync_m_q;
  logic [9:0] sync_q;
  logic [6:0] sh_q;
  logic [2:0] bit_cnt_q;
  logic first_q;
  logic rd_q;
  logic [2:0] out_idx_q;
  logic dual;
  logic sleep;
  logic [7:0] stat;
  logic [7:0] nxt;
  logic [2:0] cnt_nxt;
  logic done;

  // frame logic is cleared whenever the device is deselected
  assign frame_rst_n = i_rst_n & ~i_sel_n;
  assign dual = sync_q[8];
  assign sleep = sync_q[9];
  assign stat = sync_q[7:0];

  // level synchronisers for the reference-side state
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_m_q <= 10'h000;
      sync_q <= 10'h000;
    end else begin
      sync_m_q <= {i_sleep, i_dual, i_status};
      sync_q <= sync_m_q;
    end
  end

  // msb first, one or two bits per rising edge
  always_comb begin
    nxt = dual ? {sh_q[5:0], i_io1, i_io0} : {sh_q, i_io0};
    cnt_nxt = 3'(bit_cnt_q + (dual ? 3'h2 : 3'h1));
    done = (cnt_nxt == 3'h0);
  end

  // input shifting on the rising edge
  always_ff @(posedge i_link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sh_q <= 7'h00;
      bit_cnt_q <= 3'h0;
      first_q <= 1'b1;
      rd_q <= 1'b0;
    end else begin
      sh_q <= nxt[6:0];
      bit_cnt_q <= cnt_nxt;
      if (done) begin
        first_q <= 1'b0;
        if (first_q && nxt == `SFWP_CMD_READ_STATUS && !sleep) begin
          rd_q <= 1'b1;
        end
      end
    end
  end

  // whole bytes and pulse marks towards the reference side
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_byte <= 8'h00;
      o_byte_tgl <= 1'b0;
      o_pulse_tgl <= 1'b0;
    end else begin
      o_pulse_tgl <= ~o_pulse_tgl;
      if (done) begin
        o_byte <= nxt;
        o_byte_tgl <= ~o_byte_tgl;
      end
    end
  end

  // status read-out on the falling edge; idle level does not matter
  always_ff @(negedge i_link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_idx_q <= 3'h7;
      o_io1 <= 1'b0;
      o_io1_oe <= 1'b0;
      o_io0 <= 1'b0;
      o_io0_oe <= 1'b0;
    end else if (rd_q) begin
      o_io1 <= stat[out_idx_q];
      o_io1_oe <= 1'b1;
      o_io0 <= stat[3'(out_idx_q - 3'h1)];
      o_io0_oe <= dual;
      out_idx_q <= 3'(out_idx_q - (dual ? 3'h2 : 3'h1));
    end
  end

endmodule : sfwp_link
`default_nettype wire

// [rtl/sfwp_flash_ctl.sv]
// Purpose: command and write-protect control of a serial flash
// Assumes: array macro on the reference clock, link clock on a pin
// Notes: frames are judged when select rises, seen on reference clock
//
// Notes on behaviour
// - works with idle clock low or high
// - sample input rising, drive output falling
// - program needs enable, code, address, data
// - program up to 256 bytes within page
// - erase regions to all ones, three sizes
// - busy flag held during internal cycles
// - standby only after deselect and idle
// - deep sleep ignores all but wake
// - modifying commands need the write latch
// - latch clears at power-up and completions
// - retained protect bits refuse program, erase
// - protect bits decode to upper ranges
// - mode bits default single, dual optional
// - hardware protection freezes lock and protect
// - one-time sector refused once locked
// - one-time status write only sets lock
// - writes need pulse count multiple of eight, of four in dual mode
// - power-up delay blocks data modification
// - msb first, command byte opens frame
// - sector and block wipes need exact address
// - traffic other than status read is ignored during internal cycles
`timescale 1ns/1ns
`default_nettype none
`include "sfwp_params.svh"
module sfwp_flash_ctl #(
  parameter int P_PUW_CYCLES = `SFWP_PUW_US * `SFWP_REF_MHZ
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_LINK_CLK,
  input wire logic I_SELECT_N,
  input wire logic I_SERIAL_IN,
  output logic O_SERIAL_IN,
  output logic O_SERIAL_IN_OE,
  input wire logic I_SERIAL_OUT,
  output logic O_SERIAL_OUT,
  output logic O_SERIAL_OUT_OE,
  input wire logic I_WRITE_GUARD_N,
  input wire logic [7:0] I_NV_STATUS,
  input wire logic I_NV_ONETIME_LOCK,
  input wire logic I_ARRAY_DONE,
  output var sfwp_pkg::sfwp_arr_req_type O_ARRAY_REQ,
  output var sfwp_pkg::sfwp_status_type O_FLASH_STATUS,
  output logic O_STANDBY,
  output logic O_DEEP_SLEEP
);
  logic pulse_tgl;
  logic byte_tgl;
  logic [7:0] link_byte;
  logic [3:0] sync_m_q;
  logic [3:0] sync_s_q;
  logic [3:0] sync_d_q;
  logic frame_start;
  logic frame_end;
  logic pulse_ev;
  logic byte_ev;
  logic [2:0] pulse_cnt_q;
  logic [8:0] byte_cnt_q;
  logic [8:0] data_cnt_q;
  logic [7:0] cmd_q;
  logic [23:0] addr_q;
  logic [7:0] wr_idx_q;
  logic busy_seen_q;
  logic [7:0] page_mem [256];
  sfwp_pkg::sfwp_exec_type exec_q;
  logic [7:0] idx_q;
  logic [8:0] left_q;
  logic [23:0] run_addr_q;
  logic run_otp_q;
  logic latch_q;
  logic sleep_q;
  logic otp_mode_q;
  logic otp_lock_q;
  logic lock_q;
  logic [2:0] prot_q;
  logic [1:0] mode_q;
  logic load_pend_q;
  logic [23:0] pup_cnt_q;
  logic pup_done_q;
  logic busy;
  logic hw_prot;
  logic whole;
  logic blocked;
  logic ok_wr;
  logic go;
  sfwp_pkg::sfwp_arr_op_type go_op;
  logic set_latch;
  logic clr_latch;
  logic set_sleep;
  logic wake;
  logic otp_enter;
  logic stat_wr;
  sfwp_pkg::sfwp_status_type wr_byte;
  sfwp_pkg::sfwp_status_type nv_byte;

  // link-clock side: shifting, status read-out
  sfwp_link u_sfwp_link (
    .i_link_clk(I_LINK_CLK),
    .i_rst_n(I_RST_N),
    .i_sel_n(I_SELECT_N),
    .i_io0(I_SERIAL_IN),
    .i_io1(I_SERIAL_OUT),
    .i_dual(mode_q == `SFWP_MODE_DUAL),
    .i_sleep(sleep_q),
    .i_status(O_FLASH_STATUS),
    .o_pulse_tgl(pulse_tgl),
    .o_byte_tgl(byte_tgl),
    .o_byte(link_byte),
    .o_io0(O_SERIAL_IN),
    .o_io0_oe(O_SERIAL_IN_OE),
    .o_io1(O_SERIAL_OUT),
    .o_io1_oe(O_SERIAL_OUT_OE)
  );

  // synchronisers {select, guard, pulse, byte}, third stage for edges
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_m_q <= 4'hC;
      sync_s_q <= 4'hC;
      sync_d_q <= 4'hC;
    end else begin
      sync_m_q <= {I_SELECT_N, I_WRITE_GUARD_N, pulse_tgl, byte_tgl};
      sync_s_q <= sync_m_q;
      sync_d_q <= sync_s_q;
    end
  end

  assign frame_start = sync_d_q[3] & ~sync_s_q[3];
  assign frame_end = sync_s_q[3] & ~sync_d_q[3];
  assign pulse_ev = sync_s_q[1] ^ sync_d_q[1];
  assign byte_ev = sync_s_q[0] ^ sync_d_q[0];
  assign busy = ~exec_q[0];
  assign hw_prot = lock_q & ~sync_s_q[2];
  assign wr_byte = addr_q[7:0];

  // frame bookkeeping: pulses, bytes, command, address
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pulse_cnt_q <= 3'h0;
      byte_cnt_q <= 9'h000;
      data_cnt_q <= 9'h000;
      cmd_q <= 8'h00;
      addr_q <= 24'h00_0000;
      wr_idx_q <= 8'h00;
      busy_seen_q <= 1'b0;
    end else if (frame_start) begin
      pulse_cnt_q <= 3'h0;
      byte_cnt_q <= 9'h000;
      data_cnt_q <= 9'h000;
      busy_seen_q <= 1'b0;
    end else begin
      if (pulse_ev) begin
        pulse_cnt_q <= 3'(pulse_cnt_q + 3'h1);
      end
      if (byte_ev) begin
        if (busy) begin
          busy_seen_q <= 1'b1;
        end
        if (byte_cnt_q != 9'h1FF) begin
          byte_cnt_q <= 9'(byte_cnt_q + 9'h001);
        end
        if (byte_cnt_q == 9'h000) begin
          cmd_q <= link_byte;
        end else if (byte_cnt_q < `SFWP_HDR_BYTES) begin
          addr_q <= {addr_q[15:0], link_byte};
          wr_idx_q <= link_byte;
        end else if (!busy) begin
          wr_idx_q <= 8'(wr_idx_q + 8'h01);
          if (data_cnt_q != `SFWP_PAGE_BYTES) begin
            data_cnt_q <= 9'(data_cnt_q + 9'h001);
          end
        end
      end
    end
  end

  // page buffer, wraps inside the page
  always_ff @(posedge I_REF_CLK) begin
    if (byte_ev && !busy && byte_cnt_q >= `SFWP_HDR_BYTES) begin
      page_mem[wr_idx_q] <= link_byte;
    end
  end

  // protect decode of the upper part of the array
  function automatic logic prot_hit(input logic [2:0] bp,
                                    input logic [23:0] a);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      3'h7, 3'h6: hit = 1'b1;
      3'h5: hit = (a >= `SFWP_PROT_HALF);
      3'h4: hit = (a >= `SFWP_PROT_QUARTER);
      3'h3: hit = (a >= `SFWP_PROT_EIGHTH);
      3'h2: hit = (a >= `SFWP_PROT_SIXTEENTH);
      3'h1: hit = (a >= `SFWP_PROT_LAST);
      3'h0: hit = 1'b0;
    endcase
    return hit;
  endfunction : prot_hit

  // pulse check per mode; refusal of protected targets
  assign whole = (mode_q == `SFWP_MODE_DUAL) ? (pulse_cnt_q[1:0] == 2'h0)
                                              : (pulse_cnt_q == 3'h0);
  assign blocked = otp_mode_q ? otp_lock_q
                              : prot_hit(prot_q, addr_q);
  assign ok_wr = latch_q & whole & pup_done_q;

  // frame decode when select rises
  always_comb begin
    go = 1'b0;
    go_op = sfwp_pkg::SFWP_ARR_PROG;
    set_latch = 1'b0;
    clr_latch = 1'b0;
    set_sleep = 1'b0;
    wake = 1'b0;
    otp_enter = 1'b0;
    stat_wr = 1'b0;
    if (frame_end && sleep_q) begin
      wake = (cmd_q == `SFWP_CMD_WAKE_ID) && whole;
    end else if (frame_end && !busy && !busy_seen_q) begin
      unique case (cmd_q)
        `SFWP_CMD_WRITE_ENABLE: begin
          set_latch = whole && byte_cnt_q == 9'h001;
        end
        `SFWP_CMD_WRITE_DISABLE: begin
          clr_latch = whole && byte_cnt_q == 9'h001;
        end
        `SFWP_CMD_STATUS_WRITE: begin
          stat_wr = ok_wr && byte_cnt_q == 9'h002;
          go = stat_wr;
          go_op = sfwp_pkg::SFWP_ARR_STATUS;
        end
        `SFWP_CMD_PAGE_WRITE: begin
          go = ok_wr && byte_cnt_q > `SFWP_HDR_BYTES && !blocked;
        end
        `SFWP_CMD_WIPE_4K: begin
          go = ok_wr && byte_cnt_q == `SFWP_HDR_BYTES && !blocked;
          go_op = sfwp_pkg::SFWP_ARR_WIPE_4K;
        end
        `SFWP_CMD_WIPE_64K_A, `SFWP_CMD_WIPE_64K_B: begin
          go = ok_wr && byte_cnt_q == `SFWP_HDR_BYTES && !blocked;
          go_op = sfwp_pkg::SFWP_ARR_WIPE_64K;
        end
        `SFWP_CMD_WIPE_ALL_A, `SFWP_CMD_WIPE_ALL_B: begin
          go = ok_wr && byte_cnt_q == 9'h001 &&
               (otp_mode_q ? !otp_lock_q : prot_q == 3'h0);
          go_op = sfwp_pkg::SFWP_ARR_WIPE_ALL;
        end
        `SFWP_CMD_DEEP_SLEEP: begin
          set_sleep = whole && byte_cnt_q == 9'h001;
        end
        `SFWP_CMD_ONETIME_ENTER: begin
          otp_enter = whole && byte_cnt_q == 9'h001;
        end
        default: begin
          go = 1'b0;
        end
      endcase
    end
  end

  // value persisted by a status write
  always_comb begin
    nv_byte = '0;
    nv_byte.mode = wr_byte.mode;
    nv_byte.lock = hw_prot ? lock_q : wr_byte.lock;
    nv_byte.prot = hw_prot ? prot_q : wr_byte.prot;
  end

  // power-up write delay
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pup_cnt_q <= 24'h00_0000;
      pup_done_q <= 1'b0;
    end else if (!pup_done_q) begin
      pup_cnt_q <= 24'(pup_cnt_q + 24'h00_0001);
      pup_done_q <= (pup_cnt_q == 24'(P_PUW_CYCLES - 1));
    end
  end

  // write latch, sleep and one-time mode
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      latch_q <= 1'b0;
      sleep_q <= 1'b0;
      otp_mode_q <= 1'b0;
    end else begin
      if (set_latch) begin
        latch_q <= 1'b1;
      end else if (clr_latch || (exec_q == sfwp_pkg::SFWP_EX_WAIT &&
                                 I_ARRAY_DONE)) begin
        latch_q <= 1'b0;
      end
      if (set_sleep) begin
        sleep_q <= 1'b1;
      end else if (wake) begin
        sleep_q <= 1'b0;
      end
      if (otp_enter) begin
        otp_mode_q <= 1'b1;
      end else if (clr_latch) begin
        otp_mode_q <= 1'b0;
      end
    end
  end

  // status fields; lock, protect and one-time lock loaded from retained storage after reset, mode kept at its reset value
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      load_pend_q <= 1'b1;
      lock_q <= 1'b0;
      prot_q <= `SFWP_PROT_RST;
      mode_q <= `SFWP_MODE_RST;
      otp_lock_q <= 1'b0;
    end else if (load_pend_q) begin
      load_pend_q <= 1'b0;
      lock_q <= I_NV_STATUS[7];
      prot_q <= I_NV_STATUS[4:2];
      otp_lock_q <= I_NV_ONETIME_LOCK;
    end else if (stat_wr) begin
      if (otp_mode_q) begin
        otp_lock_q <= 1'b1;
      end else begin
        mode_q <= nv_byte.mode;
        lock_q <= nv_byte.lock;
        prot_q <= nv_byte.prot;
      end
    end
  end

  // sequencer: stream page bytes or issue one beat, then await done
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      exec_q <= sfwp_pkg::SFWP_EX_IDLE;
      O_ARRAY_REQ <= '0;
      idx_q <= 8'h00;
      left_q <= 9'h000;
      run_addr_q <= 24'h00_0000;
      run_otp_q <= 1'b0;
    end else begin
      O_ARRAY_REQ.valid <= 1'b0;
      unique case (exec_q)
        sfwp_pkg::SFWP_EX_IDLE: begin
          if (go && go_op == sfwp_pkg::SFWP_ARR_PROG) begin
            exec_q <= sfwp_pkg::SFWP_EX_STREAM;
            idx_q <= 8'(wr_idx_q - data_cnt_q[7:0]);
            left_q <= data_cnt_q;
            run_addr_q <= addr_q;
            run_otp_q <= otp_mode_q;
          end else if (go) begin
            exec_q <= sfwp_pkg::SFWP_EX_WAIT;
            O_ARRAY_REQ.valid <= 1'b1;
            O_ARRAY_REQ.last <= 1'b1;
            O_ARRAY_REQ.op <= go_op;
            O_ARRAY_REQ.otp <= otp_mode_q;
            O_ARRAY_REQ.addr <= addr_q;
            O_ARRAY_REQ.data <= (go_op == sfwp_pkg::SFWP_ARR_STATUS) ?
                                nv_byte : 8'hFF;
          end
        end
        sfwp_pkg::SFWP_EX_STREAM: begin
          O_ARRAY_REQ.valid <= 1'b1;
          O_ARRAY_REQ.last <= (left_q == 9'h001);
          O_ARRAY_REQ.op <= sfwp_pkg::SFWP_ARR_PROG;
          O_ARRAY_REQ.otp <= run_otp_q;
          O_ARRAY_REQ.addr <= {run_addr_q[23:8], idx_q};
          O_ARRAY_REQ.data <= page_mem[idx_q];
          idx_q <= 8'(idx_q + 8'h01);
          left_q <= 9'(left_q - 9'h001);
          if (left_q == 9'h001) begin
            exec_q <= sfwp_pkg::SFWP_EX_WAIT;
          end
        end
        sfwp_pkg::SFWP_EX_WAIT: begin
          if (I_ARRAY_DONE) begin
            exec_q <= sfwp_pkg::SFWP_EX_IDLE;
          end
        end
        default: begin
          exec_q <= sfwp_pkg::SFWP_EX_IDLE;
        end
      endcase
    end
  end

  // registered status byte and power state
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FLASH_STATUS <= '0;
      O_STANDBY <= 1'b0;
      O_DEEP_SLEEP <= 1'b0;
    end else begin
      O_FLASH_STATUS.busy <= busy;
      O_FLASH_STATUS.latch <= latch_q;
      O_FLASH_STATUS.prot <= prot_q;
      O_FLASH_STATUS.mode <= mode_q;
      O_FLASH_STATUS.lock <= otp_mode_q ? otp_lock_q : lock_q;
      O_STANDBY <= sync_s_q[3] & ~busy;
      O_DEEP_SLEEP <= sleep_q;
    end
  end

  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_cycle_start;
    go ##1 busy;
  endsequence

  sequence s_cycle_end;
    exec_q == sfwp_pkg::SFWP_EX_WAIT && I_ARRAY_DONE ##1 !busy;
  endsequence

  a_busy_raised: assert property (go |-> s_cycle_start)
    else $error("busy not raised after start");
  a_busy_shown: assert property (busy |=> O_FLASH_STATUS.busy)
    else $error("status busy does not follow cycle");
  a_latch_gates: assert property (go |-> latch_q && pup_done_q)
    else $error("write started without latch");
  a_latch_clears: assert property (s_cycle_end |-> !latch_q)
    else $error("latch not cleared at completion");
  a_partial_refused: assert property (!whole |-> !go)
    else $error("partial byte frame executed");
  a_prot_refused: assert property (go && go_op != sfwp_pkg::SFWP_ARR_STATUS
    && go_op != sfwp_pkg::SFWP_ARR_WIPE_ALL |-> !blocked)
    else $error("protected region accepted");
  a_sleep_quiet: assert property (sleep_q |-> !go && !set_latch)
    else $error("command ran in deep sleep");
  a_page_stays: assert property (O_ARRAY_REQ.valid && !O_ARRAY_REQ.last
    |=> O_ARRAY_REQ.valid &&
        O_ARRAY_REQ.addr[23:8] == $past(O_ARRAY_REQ.addr[23:8]))
    else $error("program left its page");
  a_wipe_ones: assert property (O_ARRAY_REQ.valid &&
    O_ARRAY_REQ.op inside {sfwp_pkg::SFWP_ARR_WIPE_4K,
      sfwp_pkg::SFWP_ARR_WIPE_64K, sfwp_pkg::SFWP_ARR_WIPE_ALL}
    |-> O_ARRAY_REQ.data == 8'hFF)
    else $error("erase value not all ones");
  a_hw_frozen: assert property (hw_prot && !load_pend_q
    |=> lock_q && prot_q == $past(prot_q))
    else $error("protect bits changed under hardware lock");

endmodule : sfwp_flash_ctl
`default_nettype wire

// [tb/sfwp_host.sv]
// Purpose: host end of the serial link, drives whole frames
// Assumes: link clock stands still between frames
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module sfwp_host (
  output logic o_clk,
  output logic o_sel_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // idle bus at power-up
  initial begin
    o_clk = 1'h0;
    o_sel_n = 1'h1;
    o_mosi = 1'h0;
  end
  // n pulses, msb first, idle level of mode 0 or 3
  task automatic frame(input logic [7:0] b[$], input int n, input bit m3,
      output logic [7:0] rd);
    o_clk = m3;
    #63 o_sel_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      o_clk = 1'h0;
      o_mosi = (i / 8 < b.size()) ? b[i / 8][7 - i % 8] : 1'h0;
      #62 o_clk = 1'h1;
      rd = {rd[6:0], i_miso};
      #63;
    end
    o_clk = m3;
    #62 o_sel_n = 1'h1;
    o_mosi = ~o_mosi;
  endtask : frame
endmodule : sfwp_host
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench of the flash command controller
// Assumes: host model on the link, array answered by the bench
// Notes: array request beats are checked against a queue of notes
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic done = 1'h0;
  logic wg = 1'h1;
  logic om = 1'h0;
  logic lclk, sel_n, mosi, sin, sin_oe, sout, sout_oe, sleep, stby;
  logic [7:0] rd;
  logic [7:0] d[3];
  logic [23:0] a;
  logic [7:0] wc[5] = '{8'hD8, 8'h52, 8'hC7, 8'h60, 8'h20};
  logic [2:0] wo[5] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h1};
  sfwp_pkg::sfwp_arr_req_type r, e;
  sfwp_pkg::sfwp_status_type st;
  sfwp_pkg::sfwp_arr_req_type q[$];
  int failures = 0;
  int compares = 0;
  // reference clock
  initial begin
    forever #20 clk = ~clk;
  end
  sfwp_host u_sfwp_host (.o_clk(lclk), .o_sel_n(sel_n), .o_mosi(mosi),
    .i_miso(sout_oe ? sout : ~sout));
  sfwp_flash_ctl #(.P_PUW_CYCLES(20)) u_sfwp_flash_ctl (.I_REF_CLK(clk),
    .I_RST_N(rst_n), .I_LINK_CLK(lclk), .I_SELECT_N(sel_n),
    .I_SERIAL_IN(sin_oe ? sin : mosi), .O_SERIAL_IN(sin),
    .O_SERIAL_IN_OE(sin_oe), .I_SERIAL_OUT(sout_oe ? sout : ~sout),
    .O_SERIAL_OUT(sout), .O_SERIAL_OUT_OE(sout_oe),
    .I_WRITE_GUARD_N(wg), .I_NV_STATUS(8'h00), .I_NV_ONETIME_LOCK(1'h0),
    .I_ARRAY_DONE(done), .O_ARRAY_REQ(r), .O_FLASH_STATUS(st),
    .O_STANDBY(stby), .O_DEEP_SLEEP(sleep));
  // compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // verdict and end of run
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // one frame, then time for judgement
  task automatic send(input logic [7:0] b[$], input int n = 0,
      input bit m3 = 1'h0);
    u_sfwp_host.frame(b, (n > 0) ? n : 8 * b.size(), m3, rd);
    repeat (20) @(negedge clk);
  endtask : send
  task automatic cmd(input logic [7:0] c, input logic [23:0] ad, input int n);
    send({c, ad[23:16], ad[15:8], ad[7:0]}, n);
  endtask : cmd
  task automatic note(input logic [2:0] op, input logic [23:0] ad,
      input logic [7:0] da, input logic lst);
    q.push_back({1'h1, lst, op, om, ad, da});
  endtask : note
  // bounded wait for the internal cycle to end
  task automatic settle();
    for (int i = 0; i < 60 && st.busy !== 1'h0; i++) @(negedge clk);
    if (st.busy !== 1'h0) begin
      check(1, 0);
      close_out();
    end
  endtask : settle
  // status write with its expected persisted byte
  task automatic swr(input logic [7:0] v, input logic [7:0] w);
    send({8'h06});
    note(3'h4, 24'h00_0000, w, 1'h1);
    send({8'h01, v});
    settle();
  endtask : swr
  // array finishes a few cycles after the final beat
  always @(negedge clk) begin
    done <= 1'h0;
    if (r.valid === 1'h1 && (r.last === 1'h1 || r.op === 3'h4)) begin
      repeat (6) @(negedge clk);
      check(st.busy, 1);
      done <= 1'h1;
    end
  end
  // oldest note is taken off whenever a request beat appears
  always @(negedge clk) begin
    if (r.valid === 1'h1) begin
      if (q.size() == 0) begin
        check(1, 0);
      end else begin
        e = q.pop_front();
        check(r.op, e.op);
        if (e.op < 3'h3) begin
          check({r.last, r.otp, r.addr, r.data},
                {e.last, e.otp, e.addr, e.data});
        end else begin
          check({r.last, r.otp, r.data},
                {e.last, e.otp, e.data});
        end
      end
    end
  end
  // main sequence
  initial begin
    void'($urandom(99217));
    a = 24'($urandom_range(32'h001E_FFFF));
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    repeat (30) @(negedge clk);
    check(st, 8'h00);
    cmd(8'h20, a, 0);
    send({8'h06});
    check(st.latch, 1);
    send({8'h05, 8'h00}, 16, 1'h1);
    check(rd, 8'h02);
    cmd(8'h20, a, 33);
    cmd(8'h20, a, 40);
    check(st.latch, 1);
    // every erase code
    foreach (wc[i]) begin
      send({8'h06});
      note(wo[i], a, 8'hFF, 1'h1);
      cmd(wc[i], a, (wo[i] == 3'h3) ? 8 : 32);
      settle();
      check(st.latch, 0);
    end
    // program wrapping inside the page
    a[7:0] = 8'hFE;
    send({8'h06});
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      note(3'h0, {a[23:8], a[7:0] + 8'(i)}, d[i], i == 2);
    end
    send({8'h02, a[23:16], a[15:8], a[7:0], d[0], d[1], d[2]});
    settle();
    // protect the top block, then try both sides of its base
    send({8'h06});
    note(3'h4, 24'h00_0000, 8'h04, 1'h1);
    send({8'h01, 8'h04});
    settle();
    check(st.prot, 3'h1);
    send({8'h06});
    cmd(8'h20, 24'h1F_0000 | a[15:0], 0);
    check(st.latch, 1);
    note(3'h1, 24'h1E_0000 | a[15:0], 8'hFF, 1'h1);
    cmd(8'h20, 24'h1E_0000 | a[15:0], 0);
    settle();
    // hardware lock freezes lock and protect, guard high frees them
    swr(8'h84, 8'h84);
    check(st, 8'h84);
    wg = 1'h0;
    swr(8'h00, 8'h84);
    check(st, 8'h84);
    wg = 1'h1;
    swr(8'h00, 8'h00);
    check(st, 8'h00);
    // one-time sector: unprotected first, programmed, then locked
    send({8'h3A});
    om = 1'h1;
    send({8'h06});
    note(3'h0, a, d[0], 1'h1);
    send({8'h02, a[23:16], a[15:8], a[7:0], d[0]});
    settle();
    swr(8'h00, 8'h00);
    check(st.lock, 1);
    send({8'h06});
    send({8'h02, a[23:16], a[15:8], a[7:0], d[0]});
    check(st.latch, 1);
    send({8'h04});
    om = 1'h0;
    check(st, 8'h00);
    // deep sleep ignores all but wake
    send({8'hB9});
    check(sleep, 1);
    send({8'h06});
    check(st.latch, 0);
    send({8'hAB, 8'h00});
    check(sleep, 0);
    check(stby, 1);
    check(q.size(), 0);
    close_out();
  end
  // hang guard
  initial begin
    #400000;
    check(1, 0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
